// [rcr_consts.svh]
// named constants for the remote calibration, reset and identification bank
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH
`define RCR_PTR_CFG_RD   8'h03
`define RCR_PTR_RATE_RD  8'h04
`define RCR_PTR_CFG_WR   8'h09
`define RCR_PTR_RATE_WR  8'h0A
`define RCR_PTR_OFS_HI   8'h11
`define RCR_PTR_OFS_LO   8'h12
`define RCR_PTR_IDEAL    8'h23
`define RCR_PTR_MAKER    8'hFE
`define RCR_CFG_POR      8'h00
`define RCR_CFG_WMASK    8'hE4
`define RCR_RATE_POR     8'h08
`define RCR_IDEAL_POR    8'h00
`define RCR_OFS_POR      12'h000
`define RCR_GC_ADDR      8'h00
`define RCR_GC_SWRESET   8'h06
`define RCR_ETA_BASE     12'h828
`define RCR_KELVIN_OFS   30'h00001112
`define RCR_RES_MAX      12'h7FF
`define RCR_RES_MIN      12'h800
`define RCR_RES_POR      16'h0000
`define RCR_RD_UNMAPPED  8'h00
`define RCR_FRAC_PAD     4'h0
`endif

// [rcr_pkg.sv]
// types shared by the calibration bank, its checker, host model and bench
package rcr_pkg;
	typedef logic [7:0] rcr_byte_t;
	typedef enum logic {RCR_IDLE, RCR_DIV} rcr_conv_e;
endpackage

// [rcr_divider.sv]
// sequential restoring divider for the ideality rescale
`timescale 1ns/1ps
module rcr_divider #(
	parameter int W = 28,
	parameter int D = 12
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         clkEn,
	input  wire logic         abort,
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [D-1:0] divisor,
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      quotient
);
	localparam int CW = $clog2(W + 1);
	logic [D:0]    remReg, remNext;
	logic [W-1:0]  quoReg, quoNext;
	logic [CW-1:0] cntReg, cntNext;
	logic          busyReg, busyNext;
	logic          doneReg, doneNext;
	logic [D:0]    shifted;

	always_comb begin
		remNext  = remReg;
		quoNext  = quoReg;
		cntNext  = cntReg;
		busyNext = busyReg;
		doneNext = 1'b0;
		shifted  = {remReg[D-1:0], quoReg[W-1]};
		if (abort) begin
			busyNext = 1'b0;
		end else if (start && !busyReg) begin
			remNext  = '0;
			quoNext  = dividend;
			cntNext  = CW'(W);
			busyNext = 1'b1;
		end else if (busyReg) begin
			// remainder stays below divisor, so one extra bit is enough
			quoNext = {quoReg[W-2:0], 1'b0};
			remNext = shifted;
			if (shifted >= {1'b0, divisor}) begin
				remNext    = shifted - {1'b0, divisor};
				quoNext[0] = 1'b1;
			end
			cntNext = cntReg - CW'(1);
			if (cntReg == CW'(1)) begin
				busyNext = 1'b0;
				doneNext = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			remReg  <= '0;
			quoReg  <= '0;
			cntReg  <= '0;
			busyReg <= 1'b0;
			doneReg <= 1'b0;
		end else if (clkEn) begin
			remReg  <= remNext;
			quoReg  <= quoNext;
			cntReg  <= cntNext;
			busyReg <= busyNext;
			doneReg <= doneNext;
		end
	end

	assign busy     = busyReg;
	assign done     = doneReg;
	assign quotient = quoReg;
endmodule

// [rcr_top.sv]
// calibration registers, remote result correction, general-call reset, maker id
// What this block does
// - the ideality correction register is written and read at pointer 23h.
// - the ideality correction is an 8-bit two's complement value from -128 to 127.
// - the ideality correction comes up as 00h so the nominal 1.008 ideality applies.
// - remote results are rescaled so the ideality becomes 1.008*2088/(2088+N).
// - a remote offset in result format is added to every remote result.
// - the all-zero general call address is acknowledged and its next byte is examined.
// - a general-call byte of 06h returns all registers to power-on and aborts conversion.
// - any other general-call byte has no effect.
// - pointer FEh reads back a fixed maker identification byte.
// - a software reset sets the configuration register to 00h.
// - a software reset sets the conversion rate register to 08h.
`timescale 1ns/1ps
`include "rcr_consts.svh"
module rcr_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2A,
	// arbitrary neutral maker code
	parameter logic [7:0] MAKER_ID = 8'hA5,
	parameter int         RAW_W    = 16
) (
	input  wire logic               clk_sys,
	input  wire logic               srst,
	input  wire logic               clkEn,
	input  wire logic               addrStb,
	input  wire rcr_pkg::rcr_byte_t addrByte,
	output logic                    addrAck,
	input  wire logic               dataStb,
	input  wire rcr_pkg::rcr_byte_t dataByte,
	input  wire logic               wrStb,
	input  wire logic               rdStb,
	input  wire rcr_pkg::rcr_byte_t ptrAddr,
	input  wire rcr_pkg::rcr_byte_t wrData,
	output rcr_pkg::rcr_byte_t      rdData,
	output logic                    rdValid,
	input  wire logic               convStart,
	input  wire logic [RAW_W-1:0]   rawRemoteK,
	output logic                    convBusy,
	output logic [15:0]             remoteResult,
	output logic                    resultValid,
	output rcr_pkg::rcr_byte_t      cfgOut,
	output rcr_pkg::rcr_byte_t      rateOut,
	output logic                    swResetPulse
);
	import rcr_pkg::*;

	localparam int DIV_W = RAW_W + 12;

	// signed ideality code plus base gives the rescale numerator factor
	function automatic logic [11:0] etaFactor(input rcr_byte_t n);
		etaFactor = `RCR_ETA_BASE + {{4{n[7]}}, n};
	endfunction

	function automatic logic [11:0] satTemp(input logic signed [29:0] v);
		if (v > $signed({18'h00000, `RCR_RES_MAX}))
			satTemp = `RCR_RES_MAX;
		else if (v < $signed({18'h3FFFF, `RCR_RES_MIN}))
			satTemp = `RCR_RES_MIN;
		else
			satTemp = v[11:0];
	endfunction

	rcr_byte_t   cfgReg, cfgNext;
	rcr_byte_t   rateReg, rateNext;
	rcr_byte_t   idealReg, idealNext;
	logic [11:0] ofsReg, ofsNext;
	logic        gcArmedReg, gcArmedNext;
	logic        swRstReg, swRstNext;
	rcr_byte_t   rdDataReg, rdDataNext;
	logic        rdValidReg, rdValidNext;
	logic        swRst;
	logic        isGc;

	assign isGc  = addrStb && (addrByte == `RCR_GC_ADDR);
	assign swRst = dataStb && gcArmedReg && (dataByte == `RCR_GC_SWRESET);

	assign addrAck = isGc || (addrStb && (addrByte[7:1] == DEV_ADDR));

	always_comb begin
		cfgNext     = cfgReg;
		rateNext    = rateReg;
		idealNext   = idealReg;
		ofsNext     = ofsReg;
		gcArmedNext = gcArmedReg;
		swRstNext   = swRst;
		rdDataNext  = rdDataReg;
		rdValidNext = 1'b0;
		// only the first byte after a general call is examined
		if (addrStb)
			gcArmedNext = isGc;
		else if (dataStb)
			gcArmedNext = 1'b0;
		if (swRst) begin
			cfgNext   = `RCR_CFG_POR;
			rateNext  = `RCR_RATE_POR;
			idealNext = `RCR_IDEAL_POR;
			ofsNext   = `RCR_OFS_POR;
		end else if (wrStb) begin
			unique case (ptrAddr)
				`RCR_PTR_CFG_WR:  cfgNext  = wrData & `RCR_CFG_WMASK;
				`RCR_PTR_RATE_WR: rateNext = wrData;
				`RCR_PTR_IDEAL:   idealNext = wrData;
				`RCR_PTR_OFS_HI:  ofsNext[11:4] = wrData;
				`RCR_PTR_OFS_LO:  ofsNext[3:0] = wrData[7:4];
				default:          cfgNext  = cfgReg;
			endcase
		end
		if (rdStb) begin
			rdValidNext = 1'b1;
			unique case (ptrAddr)
				`RCR_PTR_CFG_RD:  rdDataNext = cfgReg;
				`RCR_PTR_RATE_RD: rdDataNext = rateReg;
				`RCR_PTR_IDEAL:   rdDataNext = idealReg;
				`RCR_PTR_OFS_HI:  rdDataNext = ofsReg[11:4];
				`RCR_PTR_OFS_LO:  rdDataNext = {ofsReg[3:0], `RCR_FRAC_PAD};
				`RCR_PTR_MAKER:   rdDataNext = MAKER_ID;
				default:          rdDataNext = `RCR_RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cfgReg     <= `RCR_CFG_POR;
			rateReg    <= `RCR_RATE_POR;
			idealReg   <= `RCR_IDEAL_POR;
			ofsReg     <= `RCR_OFS_POR;
			gcArmedReg <= 1'b0;
			swRstReg   <= 1'b0;
			rdDataReg  <= `RCR_RD_UNMAPPED;
			rdValidReg <= 1'b0;
		end else if (clkEn) begin
			cfgReg     <= cfgNext;
			rateReg    <= rateNext;
			idealReg   <= idealNext;
			ofsReg     <= ofsNext;
			gcArmedReg <= gcArmedNext;
			swRstReg   <= swRstNext;
			rdDataReg  <= rdDataNext;
			rdValidReg <= rdValidNext;
		end
	end

	// conversion path: rescale by ideality, shift to celsius, add offset
	rcr_conv_e         stReg, stNext;
	logic [11:0]       convOfsReg, convOfsNext;
	logic [15:0]       resReg, resNext;
	logic              resValidReg, resValidNext;
	logic              divStart;
	logic              divDone;
	logic [DIV_W-1:0]  divQuot;
	logic [DIV_W-1:0]  dividend;
	logic signed [29:0] celsius;

	// correction latched at start, so a write mid-conversion waits a turn
	assign dividend = DIV_W'(rawRemoteK) * DIV_W'(etaFactor(idealReg));
	assign divStart = (stReg == RCR_IDLE) && convStart && !swRst;
	assign celsius  = $signed(30'(divQuot)) - $signed(`RCR_KELVIN_OFS)
		+ $signed({{18{convOfsReg[11]}}, convOfsReg});

	always_comb begin
		stNext       = stReg;
		convOfsNext  = convOfsReg;
		resNext      = resReg;
		resValidNext = 1'b0;
		unique case (stReg)
			RCR_IDLE: begin
				if (divStart) begin
					convOfsNext = ofsReg;
					stNext      = RCR_DIV;
				end
			end
			RCR_DIV: begin
				if (swRst) begin
					stNext = RCR_IDLE;
				end else if (divDone) begin
					resNext      = {satTemp(celsius), `RCR_FRAC_PAD};
					resValidNext = 1'b1;
					stNext       = RCR_IDLE;
				end
			end
		endcase
		// stored result is a register too, so it goes back to power-on
		if (swRst)
			resNext = `RCR_RES_POR;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stReg       <= RCR_IDLE;
			convOfsReg  <= `RCR_OFS_POR;
			resReg      <= `RCR_RES_POR;
			resValidReg <= 1'b0;
		end else if (clkEn) begin
			stReg       <= stNext;
			convOfsReg  <= convOfsNext;
			resReg      <= resNext;
			resValidReg <= resValidNext;
		end
	end

	rcr_divider #(
		.W (DIV_W),
		.D (12)
	) uDiv (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.clkEn    (clkEn),
		.abort    (swRst),
		.start    (divStart),
		.dividend (dividend),
		.divisor  (`RCR_ETA_BASE),
		.busy     (),
		.done     (divDone),
		.quotient (divQuot)
	);

	assign rdData       = rdDataReg;
	assign rdValid      = rdValidReg;
	assign convBusy     = (stReg == RCR_DIV);
	assign remoteResult = resReg;
	assign resultValid  = resValidReg;
	assign cfgOut       = cfgReg;
	assign rateOut      = rateReg;
	assign swResetPulse = swRstReg;
endmodule

// [rcr_chk.sv]
// port assertions for the calibration bank
`timescale 1ns/1ps
module rcr_chk #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input wire logic               clk_sys,
	input wire logic               srst,
	input wire logic               clkEn,
	input wire logic               addrStb,
	input wire rcr_pkg::rcr_byte_t addrByte,
	input wire logic               addrAck,
	input wire logic               dataStb,
	input wire rcr_pkg::rcr_byte_t dataByte,
	input wire logic               rdStb,
	input wire logic               rdValid,
	input wire logic               convBusy,
	input wire logic               resultValid,
	input wire rcr_pkg::rcr_byte_t cfgOut,
	input wire rcr_pkg::rcr_byte_t rateOut,
	input wire logic               swResetPulse
);
	import rcr_pkg::*;
	logic [5:0] busyCnt_reg;
	logic [5:0] busyCnt_next;
	// busy length counted here, a repetition of 29 would be too slow
	always_comb begin
		busyCnt_next = convBusy ? busyCnt_reg + 6'h01 : 6'h00;
	end
	always_ff @(posedge clk_sys) begin
		busyCnt_reg <= srst ? 6'h00 : busyCnt_next;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_ack_gc; addrStb && addrByte == 8'h00 |-> addrAck; endproperty
	a_ack_gc: assert property (p_ack_gc) else $error("call address not acknowledged");
	property p_ack_other;
		addrStb && addrByte != 8'h00 && addrByte[7:1] != DEV_ADDR |-> !addrAck;
	endproperty
	a_ack_other: assert property (p_ack_other) else $error("foreign address acknowledged");
	property p_rd; clkEn && rdStb |=> rdValid; endproperty
	a_rd: assert property (p_rd) else $error("read answer missing");
	property p_swr;
		addrStb && addrByte == 8'h00 ##2 dataStb && dataByte == 8'h06 |-> ##[1:2] swResetPulse;
	endproperty
	a_swr: assert property (p_swr) else $error("software reset not taken");
	property p_noswr;
		addrStb && addrByte == 8'h00 ##2 dataStb && dataByte != 8'h06 |-> ##1 !swResetPulse [*2];
	endproperty
	a_noswr: assert property (p_noswr) else $error("reset from other call byte");
	property p_por; swResetPulse |-> cfgOut == 8'h00 && rateOut == 8'h08 && !convBusy; endproperty
	a_por: assert property (p_por) else $error("state after software reset wrong");
	property p_abort; $fell(convBusy) |-> resultValid or ##[0:1] swResetPulse; endproperty
	a_abort: assert property (p_abort) else $error("conversion ended without cause");
	property p_lat; resultValid |-> busyCnt_reg == 6'h1D; endproperty
	a_lat: assert property (p_lat) else $error("conversion length wrong");
endmodule
bind rcr_top rcr_chk #(.DEV_ADDR(DEV_ADDR)) u_chk (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn),
	.addrStb(addrStb), .addrByte(addrByte), .addrAck(addrAck), .dataStb(dataStb),
	.dataByte(dataByte), .rdStb(rdStb), .rdValid(rdValid), .convBusy(convBusy),
	.resultValid(resultValid), .cfgOut(cfgOut), .rateOut(rateOut), .swResetPulse(swResetPulse));

// [rcr_host.sv]
// two-wire controller model driving register and call strobes
`timescale 1ns/1ps
module rcr_host (
	input  wire logic          clk_sys,
	output logic               addrStb,
	output rcr_pkg::rcr_byte_t addrByte,
	output logic               dataStb,
	output rcr_pkg::rcr_byte_t dataByte,
	output logic               wrStb,
	output logic               rdStb,
	output rcr_pkg::rcr_byte_t ptrAddr,
	output rcr_pkg::rcr_byte_t wrData,
	output logic               convStart,
	output logic [15:0]        rawRemoteK
);
	import rcr_pkg::*;
	initial begin
		{addrStb, dataStb, wrStb, rdStb, convStart} = '0;
		{addrByte, dataByte, ptrAddr, wrData, rawRemoteK} = '0;
	end
	// released lines flip so a stale value never passes for a fresh one
	task automatic acc(input logic w, input rcr_byte_t p, input rcr_byte_t d);
		@(posedge clk_sys);
		wrStb <= w;
		rdStb <= !w;
		ptrAddr <= p;
		wrData <= d;
		@(posedge clk_sys);
		{wrStb, rdStb} <= 2'h0;
		ptrAddr <= ~p;
		wrData <= ~d;
	endtask
	task automatic gcall(input rcr_byte_t a, input rcr_byte_t b);
		@(posedge clk_sys);
		addrStb <= 1'b1;
		addrByte <= a;
		@(posedge clk_sys);
		addrStb <= 1'b0;
		addrByte <= ~a;
		@(posedge clk_sys);
		dataStb <= 1'b1;
		dataByte <= b;
		@(posedge clk_sys);
		dataStb <= 1'b0;
		dataByte <= ~b;
	endtask
	task automatic conv(input logic [15:0] r);
		@(posedge clk_sys);
		convStart <= 1'b1;
		rawRemoteK <= r;
		@(posedge clk_sys);
		convStart <= 1'b0;
		rawRemoteK <= ~r;
	endtask
endmodule

// [rcr_top_tb_top.sv]
// self-checking bench for the calibration bank
`timescale 1ns/1ps
module rcr_top_tb_top;
	import rcr_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic clkEn = 1'b1;
	logic addrStb, dataStb, wrStb, rdStb, convStart, addrAck, rdValid;
	logic convBusy, resultValid, swResetPulse;
	rcr_byte_t addrByte, dataByte, ptrAddr, wrData, rdData, cfgOut, rateOut;
	logic [15:0] rawRemoteK, remoteResult;
	logic [15:0] qRd[$];
	logic [15:0] qRes[$];
	int n_fail = 0;
	int samples_checked = 0;
	rcr_top uut (.clk_sys, .srst, .clkEn, .addrStb, .addrByte, .addrAck, .dataStb, .dataByte,
		.wrStb, .rdStb, .ptrAddr, .wrData, .rdData, .rdValid, .convStart, .rawRemoteK, .convBusy,
		.remoteResult, .resultValid, .cfgOut, .rateOut, .swResetPulse);
	rcr_host host (.clk_sys, .addrStb, .addrByte, .dataStb, .dataByte, .wrStb, .rdStb,
		.ptrAddr, .wrData, .convStart, .rawRemoteK);
	always #4 clk_sys = ~clk_sys;
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rd(input rcr_byte_t p, input rcr_byte_t e);
		qRd.push_back({8'h00, e});
		host.acc(1'b0, p, 8'h00);
	endtask
	// kelvin code rescaled, shifted to celsius, offset added, clipped to 12 bits
	function automatic logic [15:0] expRes(int raw, int n, rcr_byte_t hi, rcr_byte_t lo);
		int o;
		int q;
		o = {hi, lo[7:4]};
		o = (o > 2047) ? o - 4096 : o;
		q = raw * (2088 + n) / 2088 - 4370 + o;
		q = (q > 2047) ? 2047 : (q < -2048) ? -2048 : q;
		return {q[11:0], 4'h0};
	endfunction
	always @(posedge clk_sys) begin
		if (rdValid === 1'b1)
			check({8'h00, rdData}, qRd.size() ? qRd.pop_front() : 16'hXXXX);
		if (resultValid === 1'b1)
			check(remoteResult, qRes.size() ? qRes.pop_front() : 16'hXXXX);
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		report_and_stop;
	end
	initial begin
		int n;
		rcr_byte_t hi, lo;
		logic [15:0] raw;
		void'($urandom(32'h4C29946E));
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		rd(8'h23, 8'h00);
		rd(8'hFE, 8'hA5);
		rd(8'h50, 8'h00);
		// both range ends first, then random corrections
		for (int i = 0; i < 6; i++) begin
			n = (i == 0) ? 127 : (i == 1) ? -128 : int'($urandom_range(255)) - 128;
			hi = 8'($urandom);
			lo = 8'($urandom);
			raw = 16'h0FA0 + 16'($urandom_range(3000));
			host.acc(1'b1, 8'h23, n[7:0]);
			rd(8'h23, n[7:0]);
			host.acc(1'b1, 8'h11, hi);
			host.acc(1'b1, 8'h12, lo);
			qRes.push_back(expRes(raw, n, hi, lo));
			host.conv(raw);
			host.acc(1'b1, 8'h23, ~n[7:0]);
			repeat (34) @(posedge clk_sys);
		end
		// frozen clock enable must swallow a write
		clkEn <= 1'b0;
		host.acc(1'b1, 8'h23, n[7:0]);
		clkEn <= 1'b1;
		rd(8'h23, ~n[7:0]);
		host.acc(1'b1, 8'h09, 8'hFF);
		host.acc(1'b1, 8'h0A, 8'h03);
		rd(8'h03, 8'hE4);
		host.gcall(8'h00, 8'h07);
		host.gcall(8'h54, 8'h06);
		rd(8'h04, 8'h03);
		host.conv(16'h1388);
		host.gcall(8'h30, 8'h06);
		host.gcall(8'h00, 8'h06);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h08);
		rd(8'h23, 8'h00);
		check(remoteResult, 16'h0000);
		repeat (40) @(posedge clk_sys);
		report_and_stop;
	end
endmodule
